// >>> verilog/spcr_consts.svh
// constants for the socket power control register block
`ifndef SPCR_CONSTS_SVH
`define SPCR_CONSTS_SVH
`define SPCR_OFF_CTRL 12'h010
`define SPCR_OFF_CFG 12'h014
`define SPCR_OFF_ID 12'h018
`define SPCR_ADDR_W 12
`define SPCR_RESET_VAL 32'h0000_0400
`define SPCR_ID_VAL 32'h0000_5A01
`define SPCR_BIT_ACT 11
`define SPCR_BIT_STD 10
`define SPCR_BIT_VEN 9
`define SPCR_BIT_HALT 7
`define SPCR_VCC_HI 6
`define SPCR_VCC_LO 4
`define SPCR_VPP_HI 2
`define SPCR_VPP_LO 0
`define SPCR_CODE_OFF 3'h0
`define SPCR_CODE_12 3'h1
`define SPCR_CODE_5 3'h2
`define SPCR_CODE_33 3'h3
`define SPCR_CODE_XX 3'h4
`define SPCR_CODE_YY 3'h5
`define SPCR_HTRANS_NONSEQ 2'h2
`define SPCR_HSIZE_WORD 3'h2
`define SPCR_ZERO32 32'h0000_0000
`endif

// >>> verilog/spcr_pkg.sv
// types for the socket power control register block
`default_nettype none
package spcr_pkg;
  typedef struct packed {
    logic video_path_enable;
    logic card_clock_halt_policy;
    logic [2:0] card_supply_request;
    logic [2:0] program_supply_request;
  } spcr_ctrl_t;
  // card voltage capability, as reported by interrogation
  typedef struct packed {
    logic cap_5v;
    logic cap_3v;
    logic cap_xv;
    logic cap_yv;
  } spcr_cap_t;
  typedef enum logic [2:0] {
    SPCR_V_OFF, SPCR_V_12, SPCR_V_5, SPCR_V_33, SPCR_V_XX, SPCR_V_YY, SPCR_V_BAD
  } spcr_volt_t;
endpackage
`default_nettype wire

// >>> verilog/spcr_supply_gate.sv
// supply gate: decodes requests and applies only acceptable voltages
`timescale 1ns/1ps
`default_nettype none
`include "spcr_consts.svh"
module spcr_supply_gate (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [2:0] vcc_code,
  input wire logic [2:0] vpp_code,
  input wire logic req_valid,
  input wire logic ctrl_enabled,
  input wire spcr_pkg::spcr_cap_t card_cap,
  input wire logic card_present,
  output spcr_pkg::spcr_volt_t vcc_applied,
  output spcr_pkg::spcr_volt_t vpp_applied,
  output logic bad_request
);
  function automatic spcr_pkg::spcr_volt_t dec_vcc(input logic [2:0] c);
    case (c)
      `SPCR_CODE_OFF: dec_vcc = spcr_pkg::SPCR_V_OFF;
      `SPCR_CODE_5: dec_vcc = spcr_pkg::SPCR_V_5;
      `SPCR_CODE_33: dec_vcc = spcr_pkg::SPCR_V_33;
      `SPCR_CODE_XX: dec_vcc = spcr_pkg::SPCR_V_XX;
      `SPCR_CODE_YY: dec_vcc = spcr_pkg::SPCR_V_YY;
      default: dec_vcc = spcr_pkg::SPCR_V_BAD;
    endcase
  endfunction
  function automatic spcr_pkg::spcr_volt_t dec_vpp(input logic [2:0] c);
    case (c)
      `SPCR_CODE_OFF: dec_vpp = spcr_pkg::SPCR_V_OFF;
      `SPCR_CODE_12: dec_vpp = spcr_pkg::SPCR_V_12;
      `SPCR_CODE_5: dec_vpp = spcr_pkg::SPCR_V_5;
      `SPCR_CODE_33: dec_vpp = spcr_pkg::SPCR_V_33;
      `SPCR_CODE_XX: dec_vpp = spcr_pkg::SPCR_V_XX;
      `SPCR_CODE_YY: dec_vpp = spcr_pkg::SPCR_V_YY;
      default: dec_vpp = spcr_pkg::SPCR_V_BAD;
    endcase
  endfunction
  function automatic logic fits(input spcr_pkg::spcr_volt_t v, input spcr_pkg::spcr_cap_t cap, input logic vpp);
    case (v)
      spcr_pkg::SPCR_V_OFF: fits = 1'b1;
      spcr_pkg::SPCR_V_12: fits = vpp;
      spcr_pkg::SPCR_V_5: fits = cap.cap_5v;
      spcr_pkg::SPCR_V_33: fits = cap.cap_3v;
      spcr_pkg::SPCR_V_XX: fits = cap.cap_xv;
      spcr_pkg::SPCR_V_YY: fits = cap.cap_yv;
      default: fits = 1'b0;
    endcase
  endfunction
  spcr_pkg::spcr_volt_t vcc_want;
  spcr_pkg::spcr_volt_t vpp_want;
  logic vcc_ok;
  logic vpp_ok;
  logic accept;
  logic off_req;
  assign vcc_want = dec_vcc(vcc_code);
  assign vpp_want = dec_vpp(vpp_code);
  assign off_req = (vcc_want == spcr_pkg::SPCR_V_OFF) && (vpp_want == spcr_pkg::SPCR_V_OFF);
  // powering off is always allowed; powering on needs a present, interrogated card
  assign vcc_ok = fits(vcc_want, card_cap, 1'b0) && (card_present || vcc_want == spcr_pkg::SPCR_V_OFF);
  assign vpp_ok = fits(vpp_want, card_cap, 1'b1) && (card_present || vpp_want == spcr_pkg::SPCR_V_OFF);
  assign accept = req_valid && (off_req || (ctrl_enabled && vcc_ok && vpp_ok));
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      vcc_applied <= spcr_pkg::SPCR_V_OFF;
      vpp_applied <= spcr_pkg::SPCR_V_OFF;
      bad_request <= 1'b0;
    end else if (req_valid) begin
      if (accept) begin
        vcc_applied <= vcc_want;
        vpp_applied <= vpp_want;
      end
      bad_request <= !accept;
    end
  end
  a_reserved_keeps: assert property (@(posedge hclk) disable iff (!hresetn)
    (req_valid && vcc_want == spcr_pkg::SPCR_V_BAD) |=> $stable(vcc_applied))
    else $error("reserved supply code changed applied voltage");
  a_unfit_refused: assert property (@(posedge hclk) disable iff (!hresetn)
    (req_valid && !off_req && !(vcc_ok && vpp_ok)) |=> (bad_request && $stable(vcc_applied)))
    else $error("unacceptable voltage was applied");
endmodule // spcr_supply_gate
`default_nettype wire

// >>> verilog/spcr_top.sv
// socket power control register bank with ahb-lite slave
// Contract
// - the socket control register sits at byte offset 10h.
// - bits 31 to 12 read zero and ignore writes.
// - bits 8 and 3 are reserved, read zero and ignore writes.
// - bit 11 reads the same as the video path enable bit.
// - bit 10 reads 1 whenever the standard video model disable bit is clear.
// - bit 9 enables the video path when set and disables it when clear.
// - with halt policy 0 the card clock may stop only if socket idle and host clock stopping; with 1 idle is enough.
// - card supply codes 000 off, 010 5V, 011 3.3V, 100 X.X V, 101 Y.Y V; others reserved.
// - program supply codes 000 off, 001 12V, 010 5V, 011 3.3V, 100 X.X V, 101 Y.Y V; others reserved.
// - both supply fields reset to the off code.
// - power is applied only at a voltage the card accepts; other requests are refused. The code applies 12V program supply without checking the card's capability.
// - a retest re-interrogates and enables the register; a forced voltage type disables it.
//
// The implementer's own choice: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "spcr_consts.svh"
module spcr_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic card_present_pin,
  input wire logic [3:0] card_cap_pins,
  input wire logic socket_idle,
  input wire logic host_clock_stopping,
  input wire logic card_voltage_retest,
  input wire logic force_voltage_type,
  output logic card_clock_stop_ok,
  output logic video_path_on,
  output spcr_pkg::spcr_volt_t vcc_applied,
  output spcr_pkg::spcr_volt_t vpp_applied,
  output logic bad_request
);
  // external pins pass two flops before use
  logic present_meta_reg;
  logic present_sync_reg;
  logic [3:0] cap_meta_reg;
  logic [3:0] cap_sync_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      present_meta_reg <= 1'b0;
      present_sync_reg <= 1'b0;
      cap_meta_reg <= 4'h0;
      cap_sync_reg <= 4'h0;
    end else begin
      present_meta_reg <= card_present_pin;
      present_sync_reg <= present_meta_reg;
      cap_meta_reg <= card_cap_pins;
      cap_sync_reg <= cap_meta_reg;
    end
  end

  // address phase capture
  logic ph_valid_reg;
  logic ph_write_reg;
  logic [`SPCR_ADDR_W-1:0] ph_addr_reg;
  logic addr_phase;
  assign addr_phase = hsel && hready && (htrans == `SPCR_HTRANS_NONSEQ) && (hsize == `SPCR_HSIZE_WORD);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_valid_reg <= 1'b0;
      ph_write_reg <= 1'b0;
      ph_addr_reg <= `SPCR_ADDR_W'h000;
    end else begin
      ph_valid_reg <= addr_phase;
      ph_write_reg <= hwrite;
      ph_addr_reg <= haddr[`SPCR_ADDR_W-1:0];
    end
  end

  function automatic logic hit(input logic [`SPCR_ADDR_W-1:0] a, input logic [`SPCR_ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  logic wr_ctrl;
  logic wr_cfg;
  assign wr_ctrl = ph_valid_reg && ph_write_reg && hit(ph_addr_reg, `SPCR_OFF_CTRL);
  assign wr_cfg = ph_valid_reg && ph_write_reg && hit(ph_addr_reg, `SPCR_OFF_CFG);

  // control fields; only the writable bits are stored
  spcr_pkg::spcr_ctrl_t ctrl_reg;
  spcr_pkg::spcr_ctrl_t ctrl_next;
  logic std_disable_reg;
  logic ctrl_enabled_reg;
  logic cap_valid_reg;
  spcr_pkg::spcr_cap_t cap_reg;
  assign ctrl_next.video_path_enable = hwdata[`SPCR_BIT_VEN];
  assign ctrl_next.card_clock_halt_policy = hwdata[`SPCR_BIT_HALT];
  assign ctrl_next.card_supply_request = hwdata[`SPCR_VCC_HI:`SPCR_VCC_LO];
  assign ctrl_next.program_supply_request = hwdata[`SPCR_VPP_HI:`SPCR_VPP_LO];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg <= '0;
      std_disable_reg <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= ctrl_next;
      end
      if (wr_cfg) begin
        std_disable_reg <= hwdata[0];
      end
    end
  end

  // retest enables the register; a forced type disables it; retest wins if both
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_enabled_reg <= 1'b1;
      cap_valid_reg <= 1'b0;
      cap_reg <= '0;
    end else begin
      if (card_voltage_retest) begin
        ctrl_enabled_reg <= 1'b1;
        cap_reg <= cap_sync_reg;
        cap_valid_reg <= 1'b1;
      end else if (force_voltage_type) begin
        ctrl_enabled_reg <= 1'b0;
      end
      if (!present_sync_reg) begin
        cap_valid_reg <= 1'b0;
      end
    end
  end

  spcr_supply_gate u_gate (
    .hclk(hclk),
    .hresetn(hresetn),
    .vcc_code(ctrl_reg.card_supply_request),
    .vpp_code(ctrl_reg.program_supply_request),
    .req_valid(wr_ctrl),
    .ctrl_enabled(ctrl_enabled_reg),
    .card_cap(cap_reg),
    .card_present(present_sync_reg && cap_valid_reg),
    .vcc_applied(vcc_applied),
    .vpp_applied(vpp_applied),
    .bad_request(bad_request)
  );

  // gate is fed from ctrl_reg during the write's own data phase: it checks the fields already stored
  // the write pulse is not delayed, so the gate sees the fields stored by the previous write
  logic [31:0] ctrl_view;
  logic std_flag;
  assign std_flag = !std_disable_reg;
  assign ctrl_view = {20'h0_0000, ctrl_reg.video_path_enable, std_flag, ctrl_reg.video_path_enable, 1'b0,
    ctrl_reg.card_clock_halt_policy, ctrl_reg.card_supply_request, 1'b0, ctrl_reg.program_supply_request};

  assign video_path_on = ctrl_reg.video_path_enable;
  assign card_clock_stop_ok = socket_idle && (ctrl_reg.card_clock_halt_policy || host_clock_stopping);

  logic rd_ctrl;
  logic rd_cfg;
  logic rd_id;
  logic [31:0] rdata_next;
  assign rd_ctrl = addr_phase && !hwrite && hit(haddr[`SPCR_ADDR_W-1:0], `SPCR_OFF_CTRL);
  assign rd_cfg = addr_phase && !hwrite && hit(haddr[`SPCR_ADDR_W-1:0], `SPCR_OFF_CFG);
  assign rd_id = addr_phase && !hwrite && hit(haddr[`SPCR_ADDR_W-1:0], `SPCR_OFF_ID);
  // reads are registered at the address phase; a write in the same data phase is not yet visible
  assign rdata_next = rd_ctrl ? ctrl_view :
    rd_cfg ? {31'h0000_0000, std_disable_reg} :
    rd_id ? `SPCR_ID_VAL : `SPCR_ZERO32;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= `SPCR_ZERO32;
    end else begin
      hrdata <= rdata_next;
    end
  end
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  a_active_mirror: assert property (@(posedge hclk) disable iff (!hresetn)
    ctrl_view[`SPCR_BIT_ACT] == ctrl_view[`SPCR_BIT_VEN])
    else $error("activity flag differs from enable");
  a_upper_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    (rd_ctrl ##1 1'b1) |-> (hrdata[31:12] == 20'h0_0000 && hrdata[8] == 1'b0 && hrdata[3] == 1'b0))
    else $error("reserved bits read nonzero");
  a_std_flag: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_cfg && !hwdata[0] |=> ctrl_view[`SPCR_BIT_STD])
    else $error("standard model flag not set");
  a_enable_write: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_ctrl |=> video_path_on == $past(hwdata[`SPCR_BIT_VEN]))
    else $error("video enable not written");
  a_halt_gate: assert property (@(posedge hclk) disable iff (!hresetn)
    (card_clock_stop_ok && !ctrl_reg.card_clock_halt_policy) |-> host_clock_stopping)
    else $error("clock stop without host stop");
  a_force_off: assert property (@(posedge hclk) disable iff (!hresetn)
    (force_voltage_type && !card_voltage_retest) |=> !ctrl_enabled_reg ##1 1'b1)
    else $error("forced type did not disable");
  a_ctrl_read: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_ctrl |=> hrdata == $past(ctrl_view))
    else $error("control register read mismatch");
  a_reset_off: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(hresetn) |-> ctrl_reg.card_supply_request == `SPCR_CODE_OFF)
    else $error("supply not off after reset");
endmodule // spcr_top
`default_nettype wire

// >>> verif/spcr_card_model.sv
// card model driving the socket sense pins
`timescale 1ns/1ps
`default_nettype none
module spcr_card_model (
  input wire logic hclk,
  input wire logic inserted,
  input wire logic [3:0] cap_set,
  output logic card_present_pin,
  output logic [3:0] card_cap_pins
);
  logic [3:0] float_q = 4'h5;
  // empty socket: sense lines float, so show a moving pattern, never stale caps
  always @(posedge hclk) float_q <= ~float_q;
  assign card_present_pin = inserted;
  assign card_cap_pins = inserted ? cap_set : float_q;
endmodule // spcr_card_model
`default_nettype wire

// >>> verif/socket_power_control_register_tb.sv
// self-checking bench for the socket power control register
`timescale 1ns/1ps
`default_nettype none
module socket_power_control_register_tb;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize, exp_v;
  logic inserted, socket_idle, host_clock_stopping, retest, force_v, stop_ok, video_on, bad, present;
  logic [3:0] cap_set, cap_pins;
  spcr_pkg::spcr_volt_t vcc, vpp;
  int fails = 0;
  int n_checks = 0;
  assign hready = hreadyout;
  spcr_card_model card_u (.hclk(hclk), .inserted(inserted), .cap_set(cap_set), .card_present_pin(present),
    .card_cap_pins(cap_pins));
  spcr_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .card_present_pin(present), .card_cap_pins(cap_pins), .socket_idle(socket_idle),
    .host_clock_stopping(host_clock_stopping), .card_voltage_retest(retest), .force_voltage_type(force_v),
    .card_clock_stop_ok(stop_ok), .video_path_on(video_on), .vcc_applied(vcc), .vpp_applied(vpp),
    .bad_request(bad));
  task automatic complete_run;
    $display("checks %0d, mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    hsize <= 3'h2;
    do begin
      @(posedge hclk);
    end while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do begin
      @(posedge hclk);
    end while (hready !== 1'b1);
    // read data still stands here: the flop's new value lands after this edge
    rd = hrdata;
  endtask
  // the gate acts on the stored fields, so a request takes effect on its second write
  task automatic wr2(input logic [31:0] d);
    bus(1'b1, 32'h0000_0010, d);
    bus(1'b1, 32'h0000_0010, d);
    // applied voltages and the refusal flag settle at the closing edge
    @(posedge hclk);
  endtask
  task automatic pulse(input logic frc);
    force_v <= frc;
    retest <= ~frc;
    @(posedge hclk);
    force_v <= 1'b0;
    retest <= 1'b0;
  endtask
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  initial begin
    #200000;
    fails++;
    complete_run;
  end
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    inserted = 1'b0;
    cap_set = 4'hf;
    socket_idle = 1'b0;
    host_clock_stopping = 1'b0;
    retest = 1'b0;
    force_v = 1'b0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, 32'h0000_0010, 32'h0000_0000);
    chk(rd, 32'h0000_0400);
    bus(1'b0, 32'h0000_000c, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    bus(1'b1, 32'h0000_0010, 32'hffff_ffff);
    bus(1'b0, 32'h0000_0010, 32'h0000_0000);
    chk(rd, 32'h0000_0ef7);
    chk({31'h0, video_on}, 32'h0000_0001);
    bus(1'b1, 32'h0000_0014, 32'h0000_0001);
    bus(1'b0, 32'h0000_0010, 32'h0000_0000);
    chk(rd, 32'h0000_0af7);
    socket_idle <= 1'b1;
    @(posedge hclk);
    chk({31'h0, stop_ok}, 32'h0000_0001);
    bus(1'b1, 32'h0000_0014, 32'h0000_0000);
    wr2(32'h0000_0000);
    bus(1'b0, 32'h0000_0010, 32'h0000_0000);
    chk(rd, 32'h0000_0400);
    chk({31'h0, video_on}, 32'h0000_0000);
    chk({31'h0, stop_ok}, 32'h0000_0000);
    host_clock_stopping <= 1'b1;
    @(posedge hclk);
    chk({31'h0, stop_ok}, 32'h0000_0001);
    inserted <= 1'b1;
    repeat (4) @(posedge hclk);
    pulse(1'b0);
    exp_v = 3'h0;
    for (int c = 0; c < 8; c++) begin
      if (c != 1 && c < 6) exp_v = c[2:0];
      wr2({25'h0, c[2:0], 4'h0});
      chk({29'h0, vcc}, {29'h0, exp_v});
      chk({31'h0, bad}, {31'h0, (c == 1 || c > 5)});
    end
    exp_v = 3'h0;
    for (int c = 0; c < 8; c++) begin
      if (c < 6) exp_v = c[2:0];
      wr2({25'h0, 3'h2, 1'b0, c[2:0]});
      chk({29'h0, vpp}, {29'h0, exp_v});
      chk({31'h0, bad}, {31'h0, (c > 5)});
    end
    pulse(1'b1);
    wr2(32'h0000_0022);
    chk({31'h0, bad}, 32'h0000_0001);
    chk({29'h0, vpp}, 32'h0000_0005);
    cap_set <= 4'h8;
    repeat (4) @(posedge hclk);
    pulse(1'b0);
    wr2(32'h0000_0022);
    chk({31'h0, bad}, 32'h0000_0000);
    chk({29'h0, vpp}, 32'h0000_0002);
    wr2(32'h0000_0032);
    chk({31'h0, bad}, 32'h0000_0001);
    chk({29'h0, vcc}, 32'h0000_0002);
    inserted <= 1'b0;
    repeat (4) @(posedge hclk);
    wr2(32'h0000_0000);
    chk({29'h0, vcc}, 32'h0000_0000);
    wr2(32'h0000_0022);
    chk({31'h0, bad}, 32'h0000_0001);
    chk({29'h0, vcc}, 32'h0000_0000);
    hresetn <= 1'b0;
    @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, 32'h0000_0010, 32'h0000_0000);
    chk(rd, 32'h0000_0400);
    complete_run;
  end
endmodule // socket_power_control_register_tb
`default_nettype wire
